// *** rtl/cmd_fifo_pkg.sv ***
// Constants, register map and decode helpers of the command FIFO router
package cmd_fifo_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h50;
	localparam logic [7:0] OFS_STAT = 8'h54;
	localparam logic [7:0] OFS_PUSH_HEAD = 8'h70;
	localparam logic [7:0] OFS_PUSH_BODY = 8'h74;
	localparam logic [7:0] OFS_PUSH_LAST = 8'h78;
	localparam logic [7:0] OFS_GEN_POP = 8'h80;
	localparam logic [7:0] OFS_MGMT_POP = 8'h84;
	localparam logic [7:0] OFS_CMD_POP = 8'h88;

	// Control register fields
	localparam int CTRL_UNSOL_EN = 0;
	localparam int CTRL_UNSOL_IRQ_EN = 1;
	localparam int CTRL_CLR_LSB = 4;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// First header quadlet fields, bit 0 is the least significant
	localparam int PRIO_LSB = 0;
	localparam int TCODE_LSB = 4;
	localparam int RETRY_LSB = 8;
	localparam int LABEL_LSB = 10;
	localparam int SPEED_LSB = 16;

	// Speed codes
	localparam logic [1:0] SPD_100 = 2'h0;
	localparam logic [1:0] SPD_200 = 2'h1;
	localparam logic [1:0] SPD_400 = 2'h2;

	// Transaction codes
	localparam logic [3:0] TC_WR_BLK = 4'h1;
	localparam logic [3:0] TC_WR_RESP = 4'h2;
	localparam logic [3:0] TC_RD_BLK = 4'h5;
	localparam logic [3:0] TC_RDQ_RESP = 4'h6;
	localparam logic [3:0] TC_RDB_RESP = 4'h7;
	localparam logic [3:0] TC_LOCK_RESP = 4'hB;

	// Label patterns
	localparam logic [3:0] LBL_MGMT_HOST = 4'h8;
	localparam logic [3:0] LBL_CMD_HOST = 4'hC;
	localparam logic [2:0] LBL_UNSOL = 3'h7;
	localparam logic [1:0] LBL_DMA = 2'h1;
	localparam logic [5:0] LBL_MGMT_AUTO = 6'h28;
	localparam logic [5:0] LBL_GEN_MAX = 6'h0E;

	// Queue and FIFO selectors
	localparam logic [1:0] Q_GEN = 2'h0;
	localparam logic [1:0] Q_MGMT = 2'h1;
	localparam logic [1:0] Q_CMD = 2'h2;
	localparam logic [1:0] Q_DATA = 2'h3;

	function automatic logic is_resp(input logic [3:0] tc);
		return tc == TC_WR_RESP || tc == TC_RDQ_RESP || tc == TC_RDB_RESP || tc == TC_LOCK_RESP;
	endfunction

	function automatic logic [5:0] label_of(input logic [31:0] h);
		return h[LABEL_LSB +: 6];
	endfunction

	function automatic logic [3:0] tcode_of(input logic [31:0] h);
		return h[TCODE_LSB +: 4];
	endfunction

endpackage

// *** rtl/cmd_fifo_router.sv ***
// Command FIFO router: transmit push ports, receive steering and pop ports
//
// Functional notes
// - Packets pushed via head, body and last ports; last port commits the packet.
// - Three read ports pop general, management and command receive FIFOs.
// - Transmit queue chosen from header label and transaction code.
// - Response label steers it into the receive FIFO paired with its queue.
// - Block read with label 10_00xx uses management queue and FIFO.
// - Block read with label 11_00xx uses command queue and FIFO.
// - Responses leave general queue; labels 00_0000-00_1110 requests pair general FIFOs.
// - Block write label 11_1xxx is unsolicited status, general queue and FIFO.
// - Sending unsolicited status with irq enable set clears the status enable.
// - Unified unsolicited status write reserves no receive slot for a response.
// - DMA labels 01_xxxx use general transmit queue and data receive FIFO.
// - Management auto fetch label 10_1000 responses go to management FIFO.
// - Command auto fetch labels 11_1xxx block read responses go to command FIFO.
// - Host requests labelled 01_xxxx get responses in data receive FIFO.
// - Quadlet packets: two address quadlets, data only for writes and read responses.
// - Header: speed 17:16, label 15:10, retry 9:8, tcode 7:4, priority 3:0.
// - Block packet second quadlet: 16-bit destination ID then offset high.
// - Fourth block quadlet: data length then extended code; payload follows.
// - Speed codes 00, 01, 10 are 100, 200, 400; 11 undefined.
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module cmd_fifo_router #(
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Transmit stream to the link queues
	output logic tx_valid,
	output logic [31:0] tx_data,
	output logic tx_first,
	output logic tx_last,
	output logic [1:0] tx_queue,
	input wire logic tx_ready,
	// Received response stream from the link
	input wire logic rx_valid,
	input wire logic [31:0] rx_data,
	input wire logic rx_first,
	input wire logic rx_last,
	output logic rx_ready,
	// Responses steered to the data receive FIFO
	output logic drx_valid,
	output logic [31:0] drx_data,
	output logic drx_first,
	output logic drx_last,
	input wire logic drx_ready,
	// Control levels
	output logic unsol_status_enable,
	output logic unsol_status_irq_enable
);

	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

	////////////////////////////////////////////////////////////////////////////
	// Routing decodes

	function automatic logic [1:0] tx_route(input logic [31:0] h);
		logic [5:0] lb;
		logic [3:0] tc;
		lb = cmd_fifo_pkg::label_of(h);
		tc = cmd_fifo_pkg::tcode_of(h);
		if (cmd_fifo_pkg::is_resp(tc)) begin
			return cmd_fifo_pkg::Q_GEN;
		end else if (tc == cmd_fifo_pkg::TC_RD_BLK && lb[5:2] == cmd_fifo_pkg::LBL_MGMT_HOST) begin
			return cmd_fifo_pkg::Q_MGMT;
		end else if (tc == cmd_fifo_pkg::TC_RD_BLK && lb[5:2] == cmd_fifo_pkg::LBL_CMD_HOST) begin
			return cmd_fifo_pkg::Q_CMD;
		end else begin
			return cmd_fifo_pkg::Q_GEN;
		end
	endfunction

	function automatic logic [1:0] rx_route(input logic [31:0] h);
		logic [5:0] lb;
		logic [3:0] tc;
		lb = cmd_fifo_pkg::label_of(h);
		tc = cmd_fifo_pkg::tcode_of(h);
		if (lb[5:4] == cmd_fifo_pkg::LBL_DMA) begin
			return cmd_fifo_pkg::Q_DATA;
		end else if (lb[5:2] == cmd_fifo_pkg::LBL_MGMT_HOST || lb == cmd_fifo_pkg::LBL_MGMT_AUTO) begin
			return cmd_fifo_pkg::Q_MGMT;
		end else if (lb[5:2] == cmd_fifo_pkg::LBL_CMD_HOST) begin
			return cmd_fifo_pkg::Q_CMD;
		end else if (lb[5:3] == cmd_fifo_pkg::LBL_UNSOL && tc == cmd_fifo_pkg::TC_RDB_RESP) begin
			return cmd_fifo_pkg::Q_CMD;
		end else begin
			return cmd_fifo_pkg::Q_GEN;
		end
	endfunction

	function automatic logic is_unsol(input logic [31:0] h);
		logic [5:0] lb;
		lb = cmd_fifo_pkg::label_of(h);
		return cmd_fifo_pkg::tcode_of(h) == cmd_fifo_pkg::TC_WR_BLK
			&& lb[5:3] == cmd_fifo_pkg::LBL_UNSOL;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Bus request decode

	logic wait_q;
	logic [31:0] rdata_q;
	logic is_head;
	logic is_body;
	logic is_last;
	logic is_tx_wr;
	logic tx_slot;
	logic take;
	logic take_rd;
	logic take_wr;
	logic [1:0] pop_sel;
	logic pop_port;

	assign is_head = avs_address == cmd_fifo_pkg::OFS_PUSH_HEAD;
	assign is_body = avs_address == cmd_fifo_pkg::OFS_PUSH_BODY;
	assign is_last = avs_address == cmd_fifo_pkg::OFS_PUSH_LAST;
	assign is_tx_wr = avs_write && (is_head || is_body || is_last);
	// Push stalls on waitrequest while the link holds the previous quadlet
	assign tx_slot = !tx_valid || tx_ready;
	assign take = (avs_read || avs_write) && wait_q && (!is_tx_wr || tx_slot);
	assign take_rd = take && avs_read;
	assign take_wr = take && avs_write;

	always_comb begin
		pop_port = 1'b1;
		pop_sel = cmd_fifo_pkg::Q_GEN;
		unique case (avs_address)
			cmd_fifo_pkg::OFS_GEN_POP: pop_sel = cmd_fifo_pkg::Q_GEN;
			cmd_fifo_pkg::OFS_MGMT_POP: pop_sel = cmd_fifo_pkg::Q_MGMT;
			cmd_fifo_pkg::OFS_CMD_POP: pop_sel = cmd_fifo_pkg::Q_CMD;
			default: pop_port = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Control register

	logic en_q;
	logic irq_en_q;
	logic in_pkt_q;
	logic unsol_pkt_q;
	logic [2:0] clr;
	logic commit;

	assign commit = take_wr && is_last && in_pkt_q;
	assign clr = (take_wr && avs_address == cmd_fifo_pkg::OFS_CTRL && avs_byteenable[0])
		? avs_writedata[cmd_fifo_pkg::CTRL_CLR_LSB +: 3] : 3'h0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en_q <= cmd_fifo_pkg::CTRL_RESET[cmd_fifo_pkg::CTRL_UNSOL_EN];
			irq_en_q <= cmd_fifo_pkg::CTRL_RESET[cmd_fifo_pkg::CTRL_UNSOL_IRQ_EN];
		end else if (take_wr && avs_address == cmd_fifo_pkg::OFS_CTRL && avs_byteenable[0]) begin
			en_q <= avs_writedata[cmd_fifo_pkg::CTRL_UNSOL_EN];
			irq_en_q <= avs_writedata[cmd_fifo_pkg::CTRL_UNSOL_IRQ_EN];
		end else if (commit && unsol_pkt_q && irq_en_q) begin
			en_q <= 1'b0;
		end
	end

	assign unsol_status_enable = en_q;
	assign unsol_status_irq_enable = irq_en_q;

	////////////////////////////////////////////////////////////////////////////
	// Transmit push path

	logic tx_valid_q;
	logic [31:0] tx_data_q;
	logic tx_first_q;
	logic tx_last_q;
	logic [1:0] tx_queue_q;
	logic [1:0] pkt_queue_q;
	logic push_ok;

	// Body and last quadlets without an open packet are dropped
	assign push_ok = take_wr && (is_head || ((is_body || is_last) && in_pkt_q));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			in_pkt_q <= 1'b0;
			unsol_pkt_q <= 1'b0;
			pkt_queue_q <= cmd_fifo_pkg::Q_GEN;
		end else if (take_wr && is_head) begin
			in_pkt_q <= 1'b1;
			unsol_pkt_q <= is_unsol(avs_writedata);
			pkt_queue_q <= tx_route(avs_writedata);
		end else if (commit) begin
			in_pkt_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_valid_q <= 1'b0;
			tx_data_q <= 32'h0;
			tx_first_q <= 1'b0;
			tx_last_q <= 1'b0;
			tx_queue_q <= cmd_fifo_pkg::Q_GEN;
		end else if (push_ok) begin
			tx_valid_q <= 1'b1;
			tx_data_q <= avs_writedata;
			tx_first_q <= is_head;
			tx_last_q <= is_last;
			tx_queue_q <= is_head ? tx_route(avs_writedata) : pkt_queue_q;
		end else if (tx_ready) begin
			tx_valid_q <= 1'b0;
		end
	end

	assign tx_valid = tx_valid_q;
	assign tx_data = tx_data_q;
	assign tx_first = tx_first_q;
	assign tx_last = tx_last_q;
	assign tx_queue = tx_queue_q;

	////////////////////////////////////////////////////////////////////////////
	// Receive steering

	logic rx_ready_q;
	logic rx_take;
	logic [1:0] rx_dest_q;
	logic [1:0] dest_now;
	logic drx_push;
	logic drx_valid_d;

	assign rx_take = rx_valid && rx_ready_q;
	// Whole packet follows the FIFO picked from its first quadlet
	assign dest_now = rx_first ? rx_route(rx_data) : rx_dest_q;
	assign drx_push = rx_take && dest_now == cmd_fifo_pkg::Q_DATA;
	assign drx_valid_d = drx_push || (drx_valid && !drx_ready);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_dest_q <= cmd_fifo_pkg::Q_GEN;
		end else if (rx_take && rx_first) begin
			rx_dest_q <= dest_now;
		end
	end

	logic drx_valid_q;
	logic [31:0] drx_data_q;
	logic drx_first_q;
	logic drx_last_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drx_valid_q <= 1'b0;
			drx_data_q <= 32'h0;
			drx_first_q <= 1'b0;
			drx_last_q <= 1'b0;
		end else begin
			drx_valid_q <= drx_valid_d;
			if (drx_push) begin
				drx_data_q <= rx_data;
				drx_first_q <= rx_first;
				drx_last_q <= rx_last;
			end
		end
	end

	assign drx_valid = drx_valid_q;
	assign drx_data = drx_data_q;
	assign drx_first = drx_first_q;
	assign drx_last = drx_last_q;

	////////////////////////////////////////////////////////////////////////////
	// Receive FIFOs: general, management, command

	logic [31:0] mem_q [3][DEPTH];
	logic [AW-1:0] wp_q [3];
	logic [AW-1:0] rp_q [3];
	logic [CW-1:0] cnt_q [3];
	logic [CW-1:0] cnt_d [3];
	logic [2:0] push;
	logic [2:0] pop;
	logic [2:0] room_d;
	logic [2:0] nonempty;

	for (genvar g = 0; g < 3; g++) begin : g_rxf
		assign push[g] = rx_take && dest_now == 2'(g);
		// Empty FIFO read leaves the pointers alone
		assign pop[g] = take_rd && pop_port && pop_sel == 2'(g) && cnt_q[g] != '0;
		assign nonempty[g] = cnt_q[g] != '0;
		assign room_d[g] = cnt_d[g] != FULL_CNT;

		always_comb begin
			cnt_d[g] = cnt_q[g];
			if (clr[g]) begin
				cnt_d[g] = '0;
			end else if (push[g] && !pop[g]) begin
				cnt_d[g] = cnt_q[g] + 1'b1;
			end else if (pop[g] && !push[g]) begin
				cnt_d[g] = cnt_q[g] - 1'b1;
			end
		end

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				cnt_q[g] <= '0;
				wp_q[g] <= '0;
				rp_q[g] <= '0;
			end else begin
				cnt_q[g] <= cnt_d[g];
				if (clr[g]) begin
					wp_q[g] <= '0;
					rp_q[g] <= '0;
				end else begin
					if (push[g]) begin
						wp_q[g] <= wp_q[g] == LAST_PTR ? '0 : wp_q[g] + 1'b1;
					end
					if (pop[g]) begin
						rp_q[g] <= rp_q[g] == LAST_PTR ? '0 : rp_q[g] + 1'b1;
					end
				end
			end
		end

		always_ff @(posedge clk) begin
			if (push[g]) begin
				mem_q[g][wp_q[g]] <= rx_data;
			end
		end
	end

	// Ready only when every FIFO and the data stage can take one more quadlet
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_ready_q <= 1'b0;
		end else begin
			rx_ready_q <= (&room_d) && !drx_valid_d;
		end
	end

	assign rx_ready = rx_ready_q;

	////////////////////////////////////////////////////////////////////////////
	// Bus answer

	logic [31:0] rd_word;

	always_comb begin
		rd_word = 32'h0;
		unique case (avs_address)
			cmd_fifo_pkg::OFS_CTRL: begin
				rd_word[cmd_fifo_pkg::CTRL_UNSOL_EN] = en_q;
				rd_word[cmd_fifo_pkg::CTRL_UNSOL_IRQ_EN] = irq_en_q;
			end
			cmd_fifo_pkg::OFS_STAT: begin
				rd_word = {8'(cnt_q[2]), 8'(cnt_q[1]), 8'(cnt_q[0]),
					3'h0, drx_valid_q, nonempty, in_pkt_q};
			end
			cmd_fifo_pkg::OFS_GEN_POP, cmd_fifo_pkg::OFS_MGMT_POP,
			cmd_fifo_pkg::OFS_CMD_POP: begin
				if (cnt_q[pop_sel] != '0) begin
					rd_word = mem_q[pop_sel][rp_q[pop_sel]];
				end
			end
			default: rd_word = 32'h0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0;
		end else begin
			wait_q <= !take;
			if (take_rd) begin
				rdata_q <= rd_word;
			end
		end
	end

	assign avs_waitrequest = wait_q;
	assign avs_readdata = rdata_q;

endmodule // cmd_fifo_router

// *** bench/cmd_fifo_router_sva.sv ***
// Checker of the command FIFO router ports
`timescale 1ns/1ps
module cmd_fifo_router_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Bus
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	// Streams
	input wire logic tx_valid,
	input wire logic [31:0] tx_data,
	input wire logic tx_first,
	input wire logic [1:0] tx_queue,
	input wire logic tx_ready,
	input wire logic drx_valid,
	input wire logic [31:0] drx_data,
	input wire logic drx_ready,
	// Levels
	input wire logic unsol_status_enable,
	input wire logic unsol_status_irq_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic is_head;
	logic [5:0] lb;
	logic [3:0] tc;
	assign is_head = tx_valid && tx_first;
	assign lb = tx_data[15:10];
	assign tc = tx_data[7:4];
	AST_ACK_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("ack longer than one cycle");
	AST_READ_LAT: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
		else $error("read not answered next cycle");
	AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("tx beat dropped before taken");
	AST_TX_MGMT: assert property (is_head && tc == 4'h5 && lb[5:2] == 4'h8
		|-> tx_queue == cmd_fifo_pkg::Q_MGMT) else $error("mgmt fetch misrouted");
	AST_TX_CMD: assert property (is_head && tc == 4'h5 && lb[5:2] == 4'hC
		|-> tx_queue == cmd_fifo_pkg::Q_CMD) else $error("cmd fetch misrouted");
	AST_TX_RESP: assert property (is_head && (tc == 4'h2 || tc == 4'h6 || tc == 4'h7
		|| tc == 4'hB) |-> tx_queue == cmd_fifo_pkg::Q_GEN) else $error("resp misrouted");
	AST_TX_UNSOL: assert property (is_head && tc == 4'h1 && lb[5:3] == 3'h7
		|-> tx_queue == cmd_fifo_pkg::Q_GEN) else $error("status write misrouted");
	AST_UNSOL_CLR: assert property ($fell(unsol_status_enable)
		&& !$past(avs_write && avs_address == 8'h50) |-> $past(unsol_status_irq_enable))
		else $error("status enable cleared without irq enable");
	AST_DRX_HOLD: assert property (drx_valid && !drx_ready |=> drx_valid
		&& $stable(drx_data)) else $error("data rx beat dropped");
endmodule // cmd_fifo_router_sva
bind cmd_fifo_router cmd_fifo_router_sva chk_i (.clk(clk), .rst_n(rst_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .tx_valid(tx_valid), .tx_data(tx_data),
	.tx_first(tx_first), .tx_queue(tx_queue), .tx_ready(tx_ready), .drx_valid(drx_valid),
	.drx_data(drx_data), .drx_ready(drx_ready), .unsol_status_enable(unsol_status_enable),
	.unsol_status_irq_enable(unsol_status_irq_enable));

// *** bench/link_model.sv ***
// Link-side partner: takes transmit beats, sends responses
`timescale 1ns/1ps
module link_model (
	// Clock
	input wire logic clk,
	// Transmit stream
	input wire logic tx_valid,
	input wire logic [31:0] tx_data,
	input wire logic tx_first,
	input wire logic tx_last,
	input wire logic [1:0] tx_queue,
	output logic tx_ready,
	// Receive stream
	output logic rx_valid,
	output logic [31:0] rx_data,
	output logic rx_first,
	output logic rx_last,
	input wire logic rx_ready,
	// Data receive stream
	input wire logic drx_valid,
	input wire logic [31:0] drx_data,
	input wire logic drx_first,
	input wire logic drx_last,
	output logic drx_ready
);
	logic [35:0] tx_log[$];
	logic [33:0] drx_log[$];
	initial begin
		tx_ready = 1'b0;
		drx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_data = 32'h0;
		rx_first = 1'b0;
		rx_last = 1'b0;
	end
	// Both sinks stall every other cycle
	always @(posedge clk) begin
		tx_ready <= ~tx_ready;
		drx_ready <= ~drx_ready;
		if (tx_valid && tx_ready)
			tx_log.push_back({tx_queue, tx_first, tx_last, tx_data});
		if (drx_valid && drx_ready)
			drx_log.push_back({drx_first, drx_last, drx_data});
	end
	// Header then one data quadlet
	task automatic send(input logic [31:0] hd, input logic [31:0] dq);
		@(posedge clk);
		for (int i = 0; i < 2; i++) begin
			rx_valid <= 1'b1;
			rx_data <= (i == 0) ? hd : dq;
			rx_first <= (i == 0);
			rx_last <= (i == 1);
			@(posedge clk);
			while (rx_ready !== 1'b1) @(posedge clk);
		end
		rx_valid <= 1'b0;
		rx_data <= ~dq;
	endtask
endmodule // link_model

// *** bench/cmd_fifo_router_tb_top.sv ***
// Self-checking bench of the command FIFO router
`timescale 1ns/1ps
module cmd_fifo_router_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, tx_data, rx_data, drx_data;
	logic avs_waitrequest, tx_valid, tx_first, tx_last, tx_ready;
	logic [1:0] tx_queue;
	logic rx_valid, rx_first, rx_last, rx_ready;
	logic drx_valid, drx_first, drx_last, drx_ready;
	logic unsol_status_enable, unsol_status_irq_enable;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #10 clk = ~clk;
	cmd_fifo_router #(.DEPTH(4)) dut (.clk(clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_first(tx_first), .tx_last(tx_last), .tx_queue(tx_queue), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_first(rx_first), .rx_last(rx_last),
		.rx_ready(rx_ready), .drx_valid(drx_valid), .drx_data(drx_data),
		.drx_first(drx_first), .drx_last(drx_last), .drx_ready(drx_ready),
		.unsol_status_enable(unsol_status_enable),
		.unsol_status_irq_enable(unsol_status_irq_enable));
	link_model lnk (.clk(clk), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_first(tx_first), .tx_last(tx_last), .tx_queue(tx_queue), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_first(rx_first), .rx_last(rx_last),
		.rx_ready(rx_ready), .drx_valid(drx_valid), .drx_data(drx_data),
		.drx_first(drx_first), .drx_last(drx_last), .drx_ready(drx_ready));
	////////////////////////////////////////////////////////////////////////////////
	// Header at 400 Mbps, zero priority, new retry code
	function automatic logic [31:0] hd(input logic [5:0] lb, input logic [3:0] tc);
		return {14'h0, 2'h2, lb, 2'h0, tc, 4'h0};
	endfunction
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_tx();
		logic [31:0] q;
		// No reserved label and code pairs
		logic [11:0] t[7] = '{{6'h20, 4'h2, 2'h0}, {6'h0E, 4'h4, 2'h0}, {6'h23, 4'h5, 2'h1},
			{6'h33, 4'h5, 2'h2}, {6'h3A, 4'h1, 2'h0}, {6'h15, 4'h4, 2'h0}, {6'h30, 4'h4, 2'h0}};
		for (int i = 0; i < 7; i++) begin
			bus(1'b1, 8'h70, hd(t[i][11:6], t[i][5:2]), q);
			bus(1'b1, 8'h74, 32'hC0 + i, q);
			bus(1'b1, 8'h78, 32'hD0 + i, q);
			while (lnk.tx_log.size() < 3) @(posedge clk);
			chk(lnk.tx_log.pop_front(), {t[i][1:0], 2'b10, hd(t[i][11:6], t[i][5:2])});
			chk(lnk.tx_log.pop_front(), {t[i][1:0], 2'b00, 32'hC0 + i});
			chk(lnk.tx_log.pop_front(), {t[i][1:0], 2'b01, 32'hD0 + i});
		end
		$display("tx routing done");
	endtask
	task automatic test_rx();
		logic [31:0] q;
		logic [17:0] t[6] = '{{6'h02, 4'h6, 8'h80}, {6'h22, 4'h7, 8'h84},
			{6'h28, 4'h7, 8'h84}, {6'h32, 4'h7, 8'h88}, {6'h3A, 4'h7, 8'h88},
			{6'h3A, 4'h2, 8'h80}};
		// Pop each packet before the next: one full FIFO stalls the link
		for (int k = 0; k < 6; k++) begin
			lnk.send(hd(t[k][17:12], t[k][11:8]), 32'hA0 + k);
			bus(1'b0, t[k][7:0], 32'h0, q);
			chk({4'h0, q}, {4'h0, hd(t[k][17:12], t[k][11:8])});
			bus(1'b0, t[k][7:0], 32'h0, q);
			chk({4'h0, q}, 36'hA0 + k);
		end
		for (int k = 0; k < 4; k++) begin
			bus(1'b0, 8'h7C + 8'(4 * k), 32'h0, q);
			chk({4'h0, q}, 36'h0);
		end
		lnk.send(hd(6'h01, 4'h6), 32'hE1);
		bus(1'b0, 8'h54, 32'h0, q);
		chk({4'h0, q}, 36'h0000_0202);
		bus(1'b1, 8'h50, 32'h10, q);
		bus(1'b0, 8'h80, 32'h0, q);
		chk({4'h0, q}, 36'h0);
		lnk.send(hd(6'h15, 4'h6), 32'hB5);
		while (lnk.drx_log.size() < 2) @(posedge clk);
		chk({2'h0, lnk.drx_log.pop_front()}, {4'h2, hd(6'h15, 4'h6)});
		chk({2'h0, lnk.drx_log.pop_front()}, {4'h1, 32'hB5});
		$display("rx steering done");
	endtask
	task automatic test_unsol();
		logic [31:0] q;
		for (int m = 0; m < 2; m++) begin
			bus(1'b1, 8'h50, {30'h0, m[0], 1'b1}, q);
			bus(1'b1, 8'h70, hd(6'h3C, 4'h1), q);
			bus(1'b1, 8'h78, 32'h0, q);
			bus(1'b0, 8'h50, 32'h0, q);
			chk({35'h0, unsol_status_irq_enable}, {35'h0, m[0]});
			chk({34'h0, q[1:0]}, {34'h0, m[0], ~m[0]});
			chk({35'h0, unsol_status_enable}, {35'h0, ~m[0]});
		end
		while (lnk.tx_log.size() < 4) @(posedge clk);
		lnk.tx_log.delete();
		$display("status write done");
	endtask
	task automatic test_done();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			test_done();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		test_tx();
		test_rx();
		test_unsol();
		test_done();
	end
endmodule // cmd_fifo_router_tb_top
